// ---- counter_array_pkg.sv ----
// Shared constants and carrier types for the counter array register block
package counter_array_pkg;

	// Array geometry
	localparam int NUM_MODULES = 6;
	localparam int WATCHDOG_MODULE = 5;

	// Counter register addresses
	localparam logic [7:0] COUNTER_LOW_ADDR = 8'hF9;
	localparam logic [7:0] COUNTER_HIGH_ADDR = 8'hFA;

	// Capture/compare addresses, index = module number (module 0 rightmost)
	localparam logic [5:0][7:0] CAPCMP_LOW_ADDR = {8'hD2, 8'hFD, 8'hED, 8'hEB, 8'hE9, 8'hFB};
	localparam logic [5:0][7:0] CAPCMP_HIGH_ADDR = {8'hD3, 8'hFE, 8'hEE, 8'hEC, 8'hEA, 8'hFC};

	// Byte positions inside a 16-bit value
	localparam int LOW_BYTE_LSB = 0;
	localparam int HIGH_BYTE_LSB = 8;

	// Reset values and unmapped read data
	localparam logic [15:0] COUNTER_RESET = 16'h0000;
	localparam logic [7:0] SNAPSHOT_RESET = 8'h00;
	localparam logic [15:0] CAPCMP_RESET = 16'h0000;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;
	localparam logic COMPARATOR_ENABLE_RESET = 1'b0;
	localparam logic [7:0] READ_DATA_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_DATA = 8'h00;

	// One register bus request, sampled on each rising clock edge
	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_req_t;

	// Per-module state seen by the capture, compare and PWM engines
	typedef struct packed {
		logic comparatorEnable;
		logic compareMatch;
		logic [15:0] capcmpValue;
		logic [15:0] reloadValue;
	} channel_t;

	// Mode register update of the comparator enable bits
	typedef struct packed {
		logic [5:0] load;
		logic [5:0] value;
	} mode_update_t;

endpackage : counter_array_pkg

// ---- counter_array_regs.sv ----
// Register access of the programmable counter array: counter, snapshot, capture/compare, reload
// Behaviour
// - 16-bit counter, low byte at 0xF9, high byte at 0xFA, both read/write.
// - High byte read returns a snapshot loaded only when the low byte is read.
// - Watchdog enabled: software writes to the counter low byte are ignored.
// - Watchdog enabled: software writes to the counter high byte are ignored.
// - Six modules each have a read/write capture/compare low byte at fixed addresses.
// - Reload select set: low-byte address reaches that channel's PWM reload low byte.
// - Six modules each have a read/write capture/compare high byte at fixed addresses.
// - Reload select set: high-byte address reaches that channel's PWM reload high byte.
// - Writing a module's low byte clears its comparator enable bit.
// - Writing a module's high byte sets its comparator enable bit.
// - Comparator enable high turns on compare of that module against the counter.
// - Watchdog enabled: module five is the watchdog, its mode bits are locked.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module counter_array_regs (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Register port
	input wire counter_array_pkg::reg_req_t regReq,
	output logic [7:0] regRdData,
	// Control from the mode and PWM configuration registers
	input wire logic watchdogEnable,
	input wire logic autoReloadSelect,
	input wire counter_array_pkg::mode_update_t modeUpdate,
	// Counter timebase
	input wire logic countTick,
	// Engine side
	output logic [15:0] counterValue,
	output counter_array_pkg::channel_t [5:0] channels
);

	logic [15:0] counter;
	logic [7:0] snapshot;
	logic [5:0][15:0] capcmp;
	logic [5:0][15:0] reload;
	logic [5:0] comparatorEnable;
	logic [5:0] compareMatch;
	logic [5:0] hitLow;
	logic [5:0] hitHigh;
	logic hitCounterLow;
	logic hitCounterHigh;
	logic counterWriteOk;
	logic [7:0] next_rdData;

	assign hitCounterLow = regReq.addr == counter_array_pkg::COUNTER_LOW_ADDR;
	assign hitCounterHigh = regReq.addr == counter_array_pkg::COUNTER_HIGH_ADDR;
	// The watchdog owns the counter; software may not move it under a running watchdog
	assign counterWriteOk = regReq.write && !watchdogEnable;

	// Counter: a software write to a byte in the same cycle as a tick wins over the tick for that byte only
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			counter <= counter_array_pkg::COUNTER_RESET;
		end else begin
			if (counterWriteOk && hitCounterLow) begin
				counter[7:0] <= regReq.data;
			end else if (countTick) begin
				counter[7:0] <= counter[7:0] + 8'h01;
			end
			if (counterWriteOk && hitCounterHigh) begin
				counter[15:8] <= regReq.data;
			end else if (countTick && counter[7:0] == 8'hFF) begin
				counter[15:8] <= counter[15:8] + 8'h01;
			end
		end
	end

	// Snapshot taken in the low-byte read cycle, so a carry between the two reads is harmless
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			snapshot <= counter_array_pkg::SNAPSHOT_RESET;
		end else if (regReq.read && hitCounterLow) begin
			snapshot <= counter[15:8];
		end
	end

	genvar m;
	generate
		for (m = 0; m < counter_array_pkg::NUM_MODULES; m++) begin : g_module
			logic modeLocked;

			assign hitLow[m] = regReq.addr == counter_array_pkg::CAPCMP_LOW_ADDR[m];
			assign hitHigh[m] = regReq.addr == counter_array_pkg::CAPCMP_HIGH_ADDR[m];
			assign modeLocked = (m == counter_array_pkg::WATCHDOG_MODULE) && watchdogEnable;

			// Capture/compare value, reached when reload select is clear
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					capcmp[m] <= counter_array_pkg::CAPCMP_RESET;
				end else if (regReq.write && !autoReloadSelect) begin
					if (hitLow[m]) begin
						capcmp[m][7:0] <= regReq.data;
					end
					if (hitHigh[m]) begin
						capcmp[m][15:8] <= regReq.data;
					end
				end
			end

			// PWM reload value, reached through the same addresses when reload select is set
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					reload[m] <= counter_array_pkg::RELOAD_RESET;
				end else if (regReq.write && autoReloadSelect) begin
					if (hitLow[m]) begin
						reload[m][7:0] <= regReq.data;
					end
					if (hitHigh[m]) begin
						reload[m][15:8] <= regReq.data;
					end
				end
			end

			// Comparator enable: byte writes override a mode update in the same cycle.
			// The watchdog module keeps its bit while the watchdog runs.
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					comparatorEnable[m] <= counter_array_pkg::COMPARATOR_ENABLE_RESET;
				end else if (!modeLocked) begin
					if (regReq.write && hitLow[m]) begin
						comparatorEnable[m] <= 1'b0;
					end else if (regReq.write && hitHigh[m]) begin
						comparatorEnable[m] <= 1'b1;
					end else if (modeUpdate.load[m]) begin
						comparatorEnable[m] <= modeUpdate.value[m];
					end
				end
			end

			// Compare against the live counter only while enabled
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					compareMatch[m] <= 1'b0;
				end else begin
					compareMatch[m] <= comparatorEnable[m] && (counter == capcmp[m]);
				end
			end

			assign channels[m].comparatorEnable = comparatorEnable[m];
			assign channels[m].compareMatch = compareMatch[m];
			assign channels[m].capcmpValue = capcmp[m];
			assign channels[m].reloadValue = reload[m];

			// Checks per module
			a_low_clears_enable: assert property (
				@(posedge core_clk) disable iff (!reset_n)
				regReq.write && hitLow[m] && !modeLocked |=> !comparatorEnable[m])
				else $error("low byte write left comparator enable set");

			a_high_sets_enable: assert property (
				@(posedge core_clk) disable iff (!reset_n)
				regReq.write && hitHigh[m] && !modeLocked |=> comparatorEnable[m])
				else $error("high byte write left comparator enable clear");

			a_compare_gated: assert property (
				@(posedge core_clk) disable iff (!reset_n)
				comparatorEnable[m] && counter == capcmp[m] |=> compareMatch[m])
				else $error("enabled compare missed a match");

			a_compare_off: assert property (
				@(posedge core_clk) disable iff (!reset_n)
				!comparatorEnable[m] |=> !compareMatch[m])
				else $error("disabled comparator reported a match");

			a_reload_routes_low: assert property (
				@(posedge core_clk) disable iff (!reset_n)
				regReq.write && hitLow[m] && autoReloadSelect
				|=> reload[m][7:0] == $past(regReq.data) && $stable(capcmp[m]))
				else $error("reload select did not steer low byte write");

			a_reload_routes_high: assert property (
				@(posedge core_clk) disable iff (!reset_n)
				regReq.write && hitHigh[m] && autoReloadSelect
				|=> reload[m][15:8] == $past(regReq.data) && $stable(capcmp[m]))
				else $error("reload select did not steer high byte write");

			a_capcmp_write: assert property (
				@(posedge core_clk) disable iff (!reset_n)
				regReq.write && (hitLow[m] || hitHigh[m]) && !autoReloadSelect
				|=> $stable(reload[m]))
				else $error("capture/compare write disturbed reload value");

			// Reads follow reload select; the enable moves only by a byte write or a mode load
			a_capcmp_low_data: assert property (
				@(posedge core_clk) disable iff (!reset_n)
				regReq.write && hitLow[m] && !autoReloadSelect
				|=> capcmp[m][7:0] == $past(regReq.data))
				else $error("capture/compare low byte write lost");

			a_capcmp_high_data: assert property (
				@(posedge core_clk) disable iff (!reset_n)
				regReq.write && hitHigh[m] && !autoReloadSelect
				|=> capcmp[m][15:8] == $past(regReq.data))
				else $error("capture/compare high byte write lost");

			a_capcmp_low_read: assert property (
				@(posedge core_clk) disable iff (!reset_n)
				regReq.read && hitLow[m] && !autoReloadSelect
				|=> regRdData == $past(capcmp[m][7:0]))
				else $error("capture/compare low byte read wrong");

			a_capcmp_high_read: assert property (
				@(posedge core_clk) disable iff (!reset_n)
				regReq.read && hitHigh[m] && !autoReloadSelect
				|=> regRdData == $past(capcmp[m][15:8]))
				else $error("capture/compare high byte read wrong");

			a_reload_low_read: assert property (
				@(posedge core_clk) disable iff (!reset_n)
				regReq.read && hitLow[m] && autoReloadSelect
				|=> regRdData == $past(reload[m][7:0]))
				else $error("reload low byte read wrong");

			a_reload_high_read: assert property (
				@(posedge core_clk) disable iff (!reset_n)
				regReq.read && hitHigh[m] && autoReloadSelect
				|=> regRdData == $past(reload[m][15:8]))
				else $error("reload high byte read wrong");

			a_watchdog_byte_lock: assert property (
				@(posedge core_clk) disable iff (!reset_n)
				modeLocked && regReq.write && (hitLow[m] || hitHigh[m])
				|=> $stable(comparatorEnable[m]))
				else $error("byte write moved the locked watchdog enable");

			a_mode_load: assert property (
				@(posedge core_clk) disable iff (!reset_n)
				modeUpdate.load[m] && !modeLocked && !(regReq.write && (hitLow[m] || hitHigh[m]))
				|=> comparatorEnable[m] == $past(modeUpdate.value[m]))
				else $error("mode load did not reach comparator enable");

			a_enable_stable: assert property (
				@(posedge core_clk) disable iff (!reset_n)
				!(regReq.write && (hitLow[m] || hitHigh[m])) && !modeUpdate.load[m]
				|=> $stable(comparatorEnable[m]))
				else $error("comparator enable moved without cause");
		end
	endgenerate

	// Read multiplexer; addresses are distinct so at most one term matches
	always_comb begin
		next_rdData = counter_array_pkg::UNMAPPED_READ_DATA;
		if (hitCounterLow) begin
			next_rdData = counter[7:0];
		end else if (hitCounterHigh) begin
			next_rdData = snapshot;
		end
		for (int i = 0; i < counter_array_pkg::NUM_MODULES; i++) begin
			if (hitLow[i]) begin
				next_rdData = autoReloadSelect ? reload[i][7:0] : capcmp[i][7:0];
			end
			if (hitHigh[i]) begin
				next_rdData = autoReloadSelect ? reload[i][15:8] : capcmp[i][15:8];
			end
		end
	end

	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			regRdData <= counter_array_pkg::READ_DATA_RESET;
		end else if (regReq.read) begin
			regRdData <= next_rdData;
		end else begin
			regRdData <= counter_array_pkg::READ_DATA_RESET;
		end
	end

	assign counterValue = counter;

	// Checks on the counter and read path
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_read_low;
		regReq.read && hitCounterLow;
	endsequence

	sequence s_read_high;
		regReq.read && hitCounterHigh;
	endsequence

	a_low_write_lands: assert property (
		counterWriteOk && hitCounterLow |=> counter[7:0] == $past(regReq.data))
		else $error("counter low byte write lost");

	a_high_write_lands: assert property (
		counterWriteOk && hitCounterHigh |=> counter[15:8] == $past(regReq.data))
		else $error("counter high byte write lost");

	a_low_write_lock: assert property (
		watchdogEnable && regReq.write && hitCounterLow && !countTick |=> $stable(counter))
		else $error("counter low byte changed under watchdog");

	a_high_write_lock: assert property (
		watchdogEnable && regReq.write && hitCounterHigh && !countTick |=> $stable(counter))
		else $error("counter high byte changed under watchdog");

	a_snapshot_load: assert property (
		s_read_low |=> snapshot == $past(counter[15:8]))
		else $error("snapshot not loaded on low byte read");

	a_snapshot_hold: assert property (
		!(regReq.read && hitCounterLow) |=> $stable(snapshot))
		else $error("snapshot changed without low byte read");

	a_coherent_pair: assert property (
		s_read_low ##1 s_read_high |=> regRdData == $past(counter[15:8], 2))
		else $error("low-then-high read not coherent");

	a_low_read_data: assert property (
		s_read_low |=> regRdData == $past(counter[7:0]))
		else $error("counter low byte read wrong");

	a_watchdog_mode_lock: assert property (
		watchdogEnable |=> comparatorEnable[counter_array_pkg::WATCHDOG_MODULE]
			== $past(comparatorEnable[counter_array_pkg::WATCHDOG_MODULE]))
		else $error("watchdog module enable changed while locked");

	a_read_one_cycle: assert property (
		!regReq.read |=> regRdData == counter_array_pkg::READ_DATA_RESET)
		else $error("read data stood beyond its cycle");

	a_high_read_data: assert property (
		s_read_high |=> regRdData == $past(snapshot))
		else $error("counter high byte read did not return the snapshot");

	// The counter moves only by a tick or an unlocked software write
	a_count_step: assert property (
		countTick && !(counterWriteOk && (hitCounterLow || hitCounterHigh))
		|=> counter == $past(counter) + 16'h0001)
		else $error("counter tick did not add one");

	a_counter_hold: assert property (
		!countTick && !counterWriteOk |=> $stable(counter))
		else $error("counter moved without tick or write");

endmodule : counter_array_regs

`default_nettype wire

// ---- sfr_master.sv ----
// Processor-side model of the special-function register bus master
`timescale 1ns/1ps
`default_nettype none
module sfr_master (
	// Clock
	input wire logic core_clk,
	// Register port
	output var counter_array_pkg::reg_req_t regReq,
	input wire logic [7:0] regRdData
);
	initial regReq = '0;
	// Each wr or rd strobe is followed by an idle edge, so no two tasks touch regReq in one step
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge core_clk);
		regReq <= {1'b1, 1'b0, addr, data};
		@(posedge core_clk);
		regReq <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(posedge core_clk);
		regReq <= {1'b0, 1'b1, addr, 8'h00};
		@(posedge core_clk);
		regReq <= '0;
		#1 data = regRdData;
	endtask : rd
	// Two reads with no gap; the first answer is taken at the edge that samples the second
	task automatic rdPair(input logic [7:0] addrA, input logic [7:0] addrB,
		output logic [7:0] dataA, output logic [7:0] dataB);
		@(posedge core_clk);
		regReq <= {1'b0, 1'b1, addrA, 8'h00};
		@(posedge core_clk);
		regReq <= {1'b0, 1'b1, addrB, 8'h00};
		@(posedge core_clk);
		dataA = regRdData;
		regReq <= '0;
		#1 dataB = regRdData;
	endtask : rdPair
endmodule : sfr_master
`default_nettype wire

// ---- test_counter_array_regs.sv ----
// Self-checking bench of the counter array register block
`timescale 1ns/1ps
`default_nettype none
module test_counter_array_regs;
	logic core_clk, reset_n, watchdogEnable, autoReloadSelect, countTick;
	counter_array_pkg::reg_req_t regReq;
	counter_array_pkg::mode_update_t modeUpdate;
	counter_array_pkg::channel_t [5:0] channels;
	logic [7:0] regRdData, rdVal, hiVal;
	logic [15:0] counterValue, cnt, d;
	logic [15:0] cap [6];
	int fails, checks, k;
	localparam logic [7:0] ADDRS [15] = '{8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hE9, 8'hEA, 8'hEB,
		8'hEC, 8'hED, 8'hEE, 8'hFD, 8'hFE, 8'hD2, 8'hD3, 8'h00};

	counter_array_regs uut (.core_clk(core_clk), .reset_n(reset_n), .regReq(regReq),
		.regRdData(regRdData), .watchdogEnable(watchdogEnable),
		.autoReloadSelect(autoReloadSelect), .modeUpdate(modeUpdate), .countTick(countTick),
		.counterValue(counterValue), .channels(channels));
	sfr_master core (.core_clk(core_clk), .regReq(regReq), .regRdData(regRdData));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	function automatic logic [7:0] byteSel(input logic [15:0] v, input bit hi);
		return hi ? v[15:8] : v[7:0];
	endfunction : byteSel

	task automatic checkVal(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : checkVal

	task automatic rdCheck(input logic [7:0] addr, input logic [7:0] exp, input string what);
		core.rd(addr, rdVal);
		checkVal({8'h00, rdVal}, {8'h00, exp}, what);
	endtask : rdCheck

	// Exactly n edges see the tick high
	task automatic tick(input int n);
		@(posedge core_clk);
		countTick <= 1'b1;
		repeat (n) @(posedge core_clk);
		countTick <= 1'b0;
	endtask : tick

	task automatic end_sim;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	initial begin
		#(20 * 5000);
		fails++;
		end_sim();
	end

	initial begin
		reset_n = 1'b0;
		watchdogEnable = 1'b0;
		autoReloadSelect = 1'b0;
		countTick = 1'b0;
		// Mode register loads stay idle until the watchdog test
		modeUpdate = '0;
		fails = 0;
		checks = 0;
		k = $urandom(76);
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		core.wr(8'h00, 8'hA5);
		foreach (ADDRS[i]) rdCheck(ADDRS[i], 8'h00, "reset value");
		$display("test reset done");
		for (int s = 0; s < 2; s++) begin
			autoReloadSelect <= s[0];
			for (int m = 0; m < 6; m++) begin
				d = 16'($urandom);
				if (s == 0) cap[m] = d;
				core.wr(counter_array_pkg::CAPCMP_LOW_ADDR[m], d[7:0]);
				#1 checkVal(16'(channels[m].comparatorEnable), 16'h0000, "enable clr");
				core.wr(counter_array_pkg::CAPCMP_HIGH_ADDR[m], d[15:8]);
				#1 checkVal(16'(channels[m].comparatorEnable), 16'h0001, "enable set");
				rdCheck(counter_array_pkg::CAPCMP_LOW_ADDR[m], d[7:0], "low");
				rdCheck(counter_array_pkg::CAPCMP_HIGH_ADDR[m], d[15:8], "high");
				checkVal(s ? channels[m].reloadValue : channels[m].capcmpValue, d, "val");
				checkVal(channels[m].capcmpValue, cap[m], "capcmp kept");
			end
		end
		$display("test capture compare done");
		autoReloadSelect <= 1'b0;
		cnt = 16'($urandom);
		core.wr(counter_array_pkg::COUNTER_LOW_ADDR, cnt[7:0]);
		core.wr(counter_array_pkg::COUNTER_HIGH_ADDR, cnt[15:8]);
		rdCheck(counter_array_pkg::COUNTER_LOW_ADDR, cnt[7:0], "cnt low");
		rdCheck(counter_array_pkg::COUNTER_HIGH_ADDR, cnt[15:8], "cnt high");
		k = 1 + $urandom_range(299);
		tick(k);
		cnt = cnt + 16'(k);
		rdCheck(counter_array_pkg::COUNTER_LOW_ADDR, byteSel(cnt, 0), "ticked");
		tick(256);
		rdCheck(counter_array_pkg::COUNTER_HIGH_ADDR, byteSel(cnt, 1), "snap");
		cnt = cnt + 16'd256;
		// Low byte rolls over between the two reads; the high byte must come from the snapshot
		core.wr(counter_array_pkg::COUNTER_LOW_ADDR, 8'hFE);
		cnt[7:0] = 8'hFE;
		countTick <= 1'b1;
		core.rdPair(counter_array_pkg::COUNTER_LOW_ADDR, counter_array_pkg::COUNTER_HIGH_ADDR,
			rdVal, hiVal);
		countTick <= 1'b0;
		checkVal({8'h00, rdVal}, 16'h00FF, "pair low");
		checkVal({8'h00, hiVal}, {8'h00, cnt[15:8]}, "pair high");
		cnt = cnt + 16'd3;
		checkVal(counterValue, cnt, "live count");
		$display("test counter done");
		watchdogEnable <= 1'b1;
		core.wr(counter_array_pkg::COUNTER_LOW_ADDR, ~cnt[7:0]);
		core.wr(counter_array_pkg::COUNTER_HIGH_ADDR, ~cnt[15:8]);
		rdCheck(counter_array_pkg::COUNTER_LOW_ADDR, cnt[7:0], "locked low");
		rdCheck(counter_array_pkg::COUNTER_HIGH_ADDR, cnt[15:8], "locked high");
		core.wr(counter_array_pkg::CAPCMP_LOW_ADDR[5], 8'h00);
		#1 checkVal(16'(channels[5].comparatorEnable), 16'h0001, "wd enable");
		@(posedge core_clk);
		modeUpdate <= {6'b100001, 6'b000000};
		@(posedge core_clk);
		modeUpdate <= '0;
		#1 checkVal(16'(channels[5].comparatorEnable), 16'h0001, "wd mode lock");
		checkVal(16'(channels[0].comparatorEnable), 16'h0000, "mode load");
		$display("test watchdog done");
		watchdogEnable <= 1'b0;
		core.wr(counter_array_pkg::CAPCMP_LOW_ADDR[0], cnt[7:0]);
		core.wr(counter_array_pkg::CAPCMP_HIGH_ADDR[0], cnt[15:8]);
		@(posedge core_clk);
		#1 checkVal(16'(channels[0].compareMatch), 16'h0001, "match");
		$display("test compare done");
		end_sim();
	end
endmodule : test_counter_array_regs
`default_nettype wire
